/* File: verilog/parallel_config_loader.sv */
// parallel configuration loader: device end of the host-clocked word interface, with an ahb-lite register slave
// assumes a single ahb-lite slave (hreadyout is hready) and asynchronous pins, all synchronised to core_clk
//
// Functional notes
// - power-on: ok low for selected delay
// - ratio 1, 4 decrypt, 8 decompress
// - user mode all high; request restarts
// - load complete only after clean stream
// - request low drops both within 600ns
// - ok low 268us, released after request
// - data width 8, 16 or 32
// - oscillator init enters user mode later
// - user clock init after gap, 8576 periods
// - init output low once option loaded
// - clock ignored after configuration completes
// - data pins released for user I/O
`timescale 1ns/1ps
module parallel_config_loader #(
  parameter int POR_FAST_CYC = cfg_loader_pkg::POR_FAST_CYC,
  parameter int POR_STD_CYC = cfg_loader_pkg::POR_STD_CYC,
  parameter int STATUS_MIN_CYC = cfg_loader_pkg::STATUS_MIN_CYC,
  parameter int OSC_INIT_CYC = cfg_loader_pkg::OSC_INIT_CYC,
  parameter int USR_INIT_PERIODS = cfg_loader_pkg::USR_INIT_PERIODS
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // configuration pins
  input wire logic cfg_request_n,
  input wire logic cfg_clock,
  input wire logic [31:0] cfg_data,
  input wire logic [2:0] mode_select_pins,
  input wire logic cfg_ok_sense_n,
  input wire logic user_init_clock,
  output logic cfg_ok_n,
  output logic load_complete,
  output logic init_complete_out,
  output logic user_io_enable,
  // received stream
  output cfg_loader_pkg::cfg_word_type cfg_word
);
  typedef enum logic [3:0] {
    ST_POR, ST_HOLD, ST_STATUS, ST_WAIT_OK, ST_LOAD, ST_FLUSH, ST_FINISH,
    ST_INIT_OSC, ST_INIT_GAP, ST_INIT_USR, ST_USER, ST_FAULT
  } state_type;

  localparam int RESP_MAX = cfg_loader_pkg::REQ_RESP_CYC;

  function automatic logic [3:0] ratio_of(input logic decomp, input logic decrypt);
    if (decomp) begin
      ratio_of = cfg_loader_pkg::RATIO_DECOMP;
    end else if (decrypt) begin
      ratio_of = cfg_loader_pkg::RATIO_DECRYPT;
    end else begin
      ratio_of = cfg_loader_pkg::RATIO_PLAIN;
    end
  endfunction

  // unused upper lanes read as zero so width never leaks into the stream
  function automatic logic [31:0] width_mask(input logic [31:0] d, input logic [1:0] w);
    if (w == cfg_loader_pkg::WIDTH_8) begin
      width_mask = {24'h00_0000, d[7:0]};
    end else if (w == cfg_loader_pkg::WIDTH_16) begin
      width_mask = {16'h0000, d[15:0]};
    end else begin
      width_mask = d;
    end
  endfunction

  // synchronised pins
  logic req_s;
  logic cfg_clock_s;
  logic ok_sense_s;
  logic usr_s;
  logic [31:0] data_s;
  logic [2:0] mode_s;

  cfg_sync #(.WIDTH(4)) u_sync_ctl (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .d({cfg_request_n, cfg_clock, cfg_ok_sense_n, user_init_clock}),
    .q({req_s, cfg_clock_s, ok_sense_s, usr_s})
  );

  cfg_sync #(.WIDTH(35)) u_sync_data (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .d({mode_select_pins, cfg_data}),
    .q({mode_s, data_s})
  );

  state_type state_ff, nxt_state;
  logic cfg_clock_d_ff;
  logic usr_d_ff;
  logic [31:0] timer_ff;
  logic [2:0] mode_ff;
  logic [3:0] ratio_ff;
  logic [3:0] phase_ff;
  logic [31:0] count_ff;
  logic [31:0] held_ff;
  logic [31:0] last_ff;
  logic error_ff;
  logic opt_ff;
  logic [1:0] fall_cnt_ff;
  logic [2:0] ctrl_ff;
  logic [31:0] length_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic cfg_ok_n_ff, load_complete_ff, init_out_ff, user_io_ff;
  logic hreadyout_ff, hresp_ff;
  logic [31:0] hrdata_ff;
  cfg_loader_pkg::cfg_word_type word_ff;

  logic cfg_clock_rise, cfg_clock_fall, usr_rise, accept, hold_bad, last_word, timer_tick;
  logic [31:0] masked;
  logic [31:0] por_len;

  assign cfg_clock_rise = cfg_clock_s & ~cfg_clock_d_ff;
  assign cfg_clock_fall = ~cfg_clock_s & cfg_clock_d_ff;
  assign usr_rise = usr_s & ~usr_d_ff;
  assign masked = width_mask(data_s, mode_ff[cfg_loader_pkg::MODE_WIDTH_LSB +: 2]);
  assign accept = (state_ff == ST_LOAD) && cfg_clock_rise && (phase_ff == 4'h0);
  assign last_word = accept && ((count_ff + 32'h1) == length_ff);
  // word must stay put while the extra clocks are spent decoding it
  assign hold_bad = ((state_ff == ST_LOAD) || (state_ff == ST_FLUSH)) && cfg_clock_rise &&
                    (phase_ff != 4'h0) && (masked != held_ff);
  assign por_len = mode_s[cfg_loader_pkg::MODE_POR_FAST_BIT] ? 32'(POR_FAST_CYC) : 32'(POR_STD_CYC);
  assign timer_tick = (state_ff == ST_INIT_USR) ? usr_rise : 1'b1;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR: if (timer_ff >= por_len) nxt_state = ST_WAIT_OK;
      ST_HOLD: if (req_s) nxt_state = ST_STATUS;
      ST_STATUS: if (timer_ff >= 32'(STATUS_MIN_CYC)) nxt_state = ST_WAIT_OK;
      ST_WAIT_OK: if (ok_sense_s) nxt_state = ST_LOAD;
      ST_LOAD: begin
        if (last_word) begin
          if (ratio_ff == cfg_loader_pkg::RATIO_PLAIN) begin
            nxt_state = error_ff ? ST_FAULT : ST_FINISH;
          end else begin
            nxt_state = ST_FLUSH;
          end
        end
      end
      ST_FLUSH: if (cfg_clock_rise && (phase_ff == 4'h1)) nxt_state = (error_ff || hold_bad) ? ST_FAULT : ST_FINISH;
      ST_FINISH: begin
        if (cfg_clock_fall && (fall_cnt_ff == 2'h1)) begin
          nxt_state = ctrl_ff[cfg_loader_pkg::CTRL_USRCLK_BIT] ? ST_INIT_GAP : ST_INIT_OSC;
        end
      end
      ST_INIT_OSC: if (timer_ff >= 32'(OSC_INIT_CYC)) nxt_state = ST_USER;
      ST_INIT_GAP: if (timer_ff >= 32'(cfg_loader_pkg::CLKUSR_GAP_CYC)) nxt_state = ST_INIT_USR;
      ST_INIT_USR: if (timer_ff >= 32'(USR_INIT_PERIODS)) nxt_state = ST_USER;
      ST_USER: nxt_state = ST_USER;
      ST_FAULT: nxt_state = ST_FAULT;
      default: nxt_state = ST_POR;
    endcase
    if ((state_ff != ST_POR) && !req_s) begin
      nxt_state = ST_HOLD;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_POR;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // the ok-low span runs on through the status state, so it counts from the request fall
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      if ((nxt_state != state_ff) && (state_ff != ST_HOLD)) begin
        timer_ff <= 32'h0000_0000;
      end else if (timer_tick && (timer_ff != 32'hffff_ffff)) begin
        timer_ff <= timer_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_clock_d_ff <= 1'b0;
      usr_d_ff <= 1'b0;
    end else if (clk_en) begin
      cfg_clock_d_ff <= cfg_clock_s;
      usr_d_ff <= usr_s;
    end
  end

  // mode pins track until power-on ends, then stay frozen
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_ff <= 3'h0;
    end else if (clk_en && (state_ff == ST_POR)) begin
      mode_ff <= mode_s;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ratio_ff <= cfg_loader_pkg::RATIO_PLAIN;
      phase_ff <= 4'h0;
      count_ff <= 32'h0000_0000;
      held_ff <= 32'h0000_0000;
      last_ff <= 32'h0000_0000;
      opt_ff <= 1'b0;
    end else if (clk_en) begin
      if (nxt_state == ST_HOLD) begin
        opt_ff <= 1'b0;
      end
      if ((state_ff == ST_WAIT_OK) && (nxt_state == ST_LOAD)) begin
        ratio_ff <= ratio_of(ctrl_ff[cfg_loader_pkg::CTRL_DECOMP_BIT], ctrl_ff[cfg_loader_pkg::CTRL_DECRYPT_BIT]);
        phase_ff <= 4'h0;
        count_ff <= 32'h0000_0000;
      end else if (accept) begin
        phase_ff <= ratio_ff - 4'h1;
        count_ff <= count_ff + 32'h1;
        held_ff <= masked;
        last_ff <= masked;
        if (count_ff == 32'h0000_0000) begin
          opt_ff <= masked[cfg_loader_pkg::OPTION_INIT_BIT];
        end
      end else if (((state_ff == ST_LOAD) || (state_ff == ST_FLUSH)) && cfg_clock_rise && (phase_ff != 4'h0)) begin
        phase_ff <= phase_ff - 4'h1;
      end
    end
  end

  // a new hold violation wins over the clear at request
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      error_ff <= 1'b0;
    end else if (clk_en) begin
      if (hold_bad) begin
        error_ff <= 1'b1;
      end else if (state_ff == ST_HOLD) begin
        error_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fall_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      if (state_ff != ST_FINISH) begin
        fall_cnt_ff <= 2'h0;
      end else if (cfg_clock_fall) begin
        fall_cnt_ff <= fall_cnt_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_ok_n_ff <= 1'b0;
      load_complete_ff <= 1'b0;
      init_out_ff <= 1'b1;
      user_io_ff <= 1'b0;
      word_ff <= '0;
    end else if (clk_en) begin
      cfg_ok_n_ff <= !((state_ff == ST_POR) || (state_ff == ST_HOLD) || (state_ff == ST_STATUS) ||
                       (state_ff == ST_FAULT));
      load_complete_ff <= (state_ff == ST_FINISH) || (state_ff == ST_INIT_OSC) || (state_ff == ST_INIT_GAP) ||
                          (state_ff == ST_INIT_USR) || (state_ff == ST_USER);
      init_out_ff <= !(opt_ff && (state_ff != ST_USER) && (state_ff != ST_HOLD));
      user_io_ff <= (state_ff == ST_USER);
      word_ff.valid <= accept;
      if (accept) begin
        word_ff.data <= masked;
      end
    end
  end

  // ahb-lite slave, zero wait states, always okay
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      ctrl_ff <= cfg_loader_pkg::CTRL_RST;
      length_ff <= cfg_loader_pkg::LENGTH_RST;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_pend_ff) begin
        if (wr_addr_ff == cfg_loader_pkg::CTRL_ADDR) ctrl_ff <= hwdata[2:0];
        if (wr_addr_ff == cfg_loader_pkg::LENGTH_ADDR) length_ff <= hwdata;
      end
      wr_pend_ff <= 1'b0;
      if (hsel && hready && (htrans == cfg_loader_pkg::HTRANS_NONSEQ)) begin
        wr_pend_ff <= hwrite;
        wr_addr_ff <= haddr[7:0];
        hrdata_ff <= 32'h0000_0000;
        if (!hwrite && (haddr[31:8] == 24'h00_0000)) begin
          case (haddr[7:0])
            cfg_loader_pkg::CTRL_ADDR: hrdata_ff <= {29'h0000_0000, ctrl_ff};
            cfg_loader_pkg::LENGTH_ADDR: hrdata_ff <= length_ff;
            cfg_loader_pkg::STATUS_ADDR: begin
              hrdata_ff <= 32'h0000_0000;
              hrdata_ff[cfg_loader_pkg::STAT_STATE_LSB +: 4] <= state_ff;
              hrdata_ff[cfg_loader_pkg::STAT_DONE_BIT] <= load_complete_ff;
              hrdata_ff[cfg_loader_pkg::STAT_OK_BIT] <= cfg_ok_n_ff;
              hrdata_ff[cfg_loader_pkg::STAT_ERR_BIT] <= error_ff;
              hrdata_ff[cfg_loader_pkg::STAT_USER_BIT] <= user_io_ff;
            end
            cfg_loader_pkg::COUNT_ADDR: hrdata_ff <= count_ff;
            cfg_loader_pkg::LAST_WORD_ADDR: hrdata_ff <= last_ff;
            default: hrdata_ff <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign cfg_ok_n = cfg_ok_n_ff;
  assign load_complete = load_complete_ff;
  assign init_complete_out = init_out_ff;
  assign user_io_enable = user_io_ff;
  assign cfg_word = word_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_req_fall;
    $fell(req_s) ##0 clk_en ##1 clk_en;
  endsequence

  sequence s_user_entry;
    (state_ff == ST_INIT_OSC) ##1 (state_ff == ST_USER);
  endsequence

  a_por_ok_low: assert property ((state_ff == ST_POR) |=> !cfg_ok_n_ff)
    else $error("ok released during power-on");
  a_ratio_pick: assert property ((state_ff == ST_FLUSH) |-> (ratio_ff == 4'h4 || ratio_ff == 4'h8))
    else $error("flush with a ratio other than 4 or 8");
  a_req_drops: assert property (s_req_fall |=> (!load_complete_ff && !cfg_ok_n_ff))
    else $error("outputs not low after request fall");
  a_resp_bound: assert property ($fell(req_s) |-> ##[1:RESP_MAX] !cfg_ok_n_ff)
    else $error("ok not low within response time");
  a_done_clean: assert property ($rose(load_complete_ff) |-> (count_ff == length_ff && !error_ff))
    else $error("load complete without clean full stream");
  a_status_min: assert property ($rose(cfg_ok_n_ff) && $past(state_ff, 2) == ST_STATUS |->
    $past(timer_ff, 2) >= 32'(STATUS_MIN_CYC))
    else $error("ok low span too short");
  a_accept_load: assert property (word_ff.valid |-> $past(state_ff) == ST_LOAD && $past(cfg_clock_rise))
    else $error("word taken outside loading");
  a_user_mode: assert property ((state_ff == ST_USER) && clk_en |=>
    (cfg_ok_n_ff && load_complete_ff && user_io_ff))
    else $error("user mode outputs wrong");
  a_osc_init: assert property (s_user_entry |-> $past(timer_ff) >= 32'(OSC_INIT_CYC))
    else $error("user mode entered too early");
  a_usr_gap: assert property ((state_ff == ST_INIT_GAP) ##1 (state_ff == ST_INIT_USR) |->
    $past(timer_ff) >= 32'(cfg_loader_pkg::CLKUSR_GAP_CYC))
    else $error("user init clock enabled too soon");
  a_init_low: assert property (opt_ff && (state_ff == ST_FINISH) && clk_en |=> !init_out_ff)
    else $error("init output not low during init");
  a_clock_ignored: assert property ((state_ff == ST_USER) |-> !accept && (nxt_state != ST_FINISH))
    else $error("cfg clock acted on after configuration");
  a_io_release: assert property (user_io_ff |-> load_complete_ff && cfg_ok_n_ff)
    else $error("pins released before configuration");
endmodule // parallel_config_loader

/* File: verilog/cfg_loader_pkg.sv */
// constants, register map and carrier types for the parallel configuration loader
// assumes a 40 MHz core clock; all pin inputs are synchronised before use
package cfg_loader_pkg;

  // core clock
  localparam int CORE_CLK_PERIOD_NS = 25;

  // times in their own units
  localparam int POR_FAST_MS = 4;
  localparam int POR_STD_MS = 100;
  localparam int STATUS_MIN_US = 268;
  localparam int OSC_INIT_MIN_US = 175;
  localparam int REQ_RESP_MAX_NS = 600;
  localparam int CFG_CLK_MIN_PERIOD_NS = 10;
  localparam int CLKUSR_GAP_PERIODS = 4;
  localparam int USR_INIT_PERIODS = 8576;

  // derived cycle counts: least times round up, longest round down
  localparam int POR_FAST_CYC = (POR_FAST_MS * 1000000 + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int POR_STD_CYC = (POR_STD_MS * 1000000 + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int OSC_INIT_CYC = (OSC_INIT_MIN_US * 1000 + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int REQ_RESP_CYC = REQ_RESP_MAX_NS / CORE_CLK_PERIOD_NS;
  localparam int CLKUSR_GAP_CYC =
    (CLKUSR_GAP_PERIODS * CFG_CLK_MIN_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

  // clock-to-word ratios
  localparam logic [3:0] RATIO_PLAIN = 4'h1;
  localparam logic [3:0] RATIO_DECRYPT = 4'h4;
  localparam logic [3:0] RATIO_DECOMP = 4'h8;

  // mode pin fields
  localparam int MODE_WIDTH_LSB = 0;
  localparam int MODE_POR_FAST_BIT = 2;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;

  // register byte offsets
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] LENGTH_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] COUNT_ADDR = 8'h0c;
  localparam logic [7:0] LAST_WORD_ADDR = 8'h10;

  // control fields and reset values
  localparam int CTRL_DECOMP_BIT = 0;
  localparam int CTRL_DECRYPT_BIT = 1;
  localparam int CTRL_USRCLK_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] LENGTH_RST = 32'h0000_0100;

  // status fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_OK_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_USER_BIT = 3;
  localparam int STAT_STATE_LSB = 8;

  // option bit position in the first stream word
  localparam int OPTION_INIT_BIT = 0;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } cfg_word_type;

endpackage

/* File: verilog/cfg_sync.sv */
// two-flop synchroniser for pin inputs, any width
// assumes each bit is a slow level; multi-bit buses must be stable around sampling
`timescale 1ns/1ps
module cfg_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // pin side and core side
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else if (clk_en) begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // cfg_sync

/* File: tb/cfg_host.sv */
// host model: drives the configuration pins of the loader from outside
// assumes a 200 ns link clock that stands low between frames
`timescale 1ns/1ps
module cfg_host (
  // pins toward the loader
  output logic cfg_clock,
  output logic [31:0] cfg_data,
  output logic cfg_request_n,
  output logic user_init_clock
);
  initial begin
    cfg_clock = 1'b0;
    cfg_data = 32'h0;
    cfg_request_n = 1'b1;
    user_init_clock = 1'b0;
  end

  task automatic set_req(input logic v);
    cfg_request_n <= v;
  endtask

  // one 200 ns period, both phases far above the minimum
  task automatic pulse();
    #100 cfg_clock = 1'b1;
    #100 cfg_clock = 1'b0;
  endtask

  // n words, each held over r rises; corrupt breaks the hold on purpose
  task automatic send(input int n, input int r, input logic [31:0] first, input bit corrupt);
    // odd offset keeps pin edges away from the core clock edge
    #2010;
    for (int i = 0; i < n; i++) begin
      cfg_data = first + i * 32'h0102_0304;
      for (int k = 0; k < r; k++) begin
        pulse();
        if (corrupt && k == 1) cfg_data = ~cfg_data;
      end
    end
    // released: no longer shows the last word
    cfg_data = ~cfg_data;
  endtask

  task automatic uclk(input int n);
    repeat (n) begin
      #100 user_init_clock = 1'b1;
      #100 user_init_clock = 1'b0;
    end
  endtask
endmodule // cfg_host

/* File: tb/parallel_config_loader_test.sv */
// self-checking bench for the parallel configuration loader
// assumes the host model drives the pins and ahb-lite reaches the registers
`timescale 1ns/1ps
module parallel_config_loader_test;
  localparam int POR_F = 20;
  localparam int POR_S = 40;
  localparam int OSC = 10;
  logic core_clk, reset, hsel, hwrite, hreadyout, hresp;
  logic clk_en, ok_hold_n, ok_line_n;
  logic cfg_request_n, cfg_clock, user_init_clock;
  logic cfg_ok_n, load_complete, init_complete_out, user_io_enable;
  logic [1:0] htrans;
  logic [2:0] mode_select_pins, hsize;
  logic [31:0] haddr, hwdata, hrdata, cfg_data, rd;
  cfg_loader_pkg::cfg_word_type cfg_word;
  logic [31:0] got[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int since_rst = 0;

  // ok line as wired on the board: the bench may hold it low from outside
  assign ok_line_n = cfg_ok_n & ok_hold_n;

  parallel_config_loader #(.POR_FAST_CYC(POR_F), .POR_STD_CYC(POR_S),
    .OSC_INIT_CYC(OSC), .USR_INIT_PERIODS(8)) uut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cfg_request_n(cfg_request_n), .cfg_clock(cfg_clock), .cfg_data(cfg_data),
    .mode_select_pins(mode_select_pins), .cfg_ok_sense_n(ok_line_n), .user_init_clock(user_init_clock),
    .cfg_ok_n(cfg_ok_n), .load_complete(load_complete), .init_complete_out(init_complete_out),
    .user_io_enable(user_io_enable), .cfg_word(cfg_word));

  cfg_host host (.cfg_clock(cfg_clock), .cfg_data(cfg_data), .cfg_request_n(cfg_request_n),
    .user_init_clock(user_init_clock));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    since_rst <= reset ? 0 : since_rst + 1;
    if (cfg_word.valid === 1'b1) got.push_back(cfg_word.data);
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= cfg_loader_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // reset, program during power-on, wait for the ok line
  task automatic boot(input logic [2:0] mode, input logic [2:0] ctrl, input logic [31:0] len);
    int p;
    p = mode[2] ? POR_F : POR_S;
    @(posedge core_clk);
    reset <= 1'b1;
    mode_select_pins <= mode;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    ahb(1'b0, cfg_loader_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl rst", rd, {29'h0, cfg_loader_pkg::CTRL_RST});
    chk("ok_n por", {31'h0, cfg_ok_n}, 32'h0);
    ahb(1'b1, cfg_loader_pkg::CTRL_ADDR, {29'h0, ctrl});
    ahb(1'b0, cfg_loader_pkg::LENGTH_ADDR, 32'h0);
    chk("len rst", rd, cfg_loader_pkg::LENGTH_RST);
    ahb(1'b1, cfg_loader_pkg::LENGTH_ADDR, len);
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    while (cfg_ok_n !== 1'b1) @(posedge core_clk);
    chk("por time", {31'h0, since_rst >= p && since_rst <= p + 8}, 32'h1);
    got.delete();
  endtask

  task automatic load(input int n, input int r, input logic [31:0] first, input logic [31:0] mask, input bit bad);
    host.send(n, r, first, bad);
    for (int k = 0; k < 20 && load_complete !== 1'b1; k++) @(posedge core_clk);
    chk("done", {31'h0, load_complete}, {31'h0, !bad});
    if (!bad) begin
      chk("count", got.size(), n);
      foreach (got[i]) chk("word", got[i], (first + i * 32'h0102_0304) & mask);
      chk("init low", {31'h0, init_complete_out}, {31'h0, ~first[0]});
    end
  endtask

  // the last data pulse falls after load_complete rises, so it is the first of the two falls
  task automatic to_user(input bit usr);
    int k;
    #10;
    host.pulse();
    if (usr) begin
      host.pulse();
      host.uclk(7);
      repeat (4) @(posedge core_clk);
      chk("early user", {31'h0, user_io_enable}, 32'h0);
      host.uclk(1);
    end
    for (k = 0; k < 40 && user_io_enable !== 1'b1; k++) @(posedge core_clk);
    chk("user", {29'h0, user_io_enable, cfg_ok_n, load_complete}, 32'h7);
    if (!usr) chk("init time", {31'h0, k >= OSC && k <= OSC + 8}, 32'h1);
    chk("init out", {31'h0, init_complete_out}, 32'h1);
    if (!usr) host.pulse();
  endtask

  // a request while frozen must not reach the core; held past the minimum width
  task automatic freeze();
    clk_en <= 1'b0;
    host.set_req(1'b0);
    repeat (80) @(posedge core_clk);
    chk("frozen", {30'h0, cfg_ok_n, user_io_enable}, 32'h3);
    host.set_req(1'b1);
    repeat (4) @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("thawed", {30'h0, cfg_ok_n, user_io_enable}, 32'h3);
  endtask

  task automatic request(input bit hold);
    int k;
    ok_hold_n <= !hold;
    host.set_req(1'b0);
    repeat (24) @(posedge core_clk);
    chk("req drop", {30'h0, cfg_ok_n, load_complete}, 32'h0);
    repeat (56) @(posedge core_clk);
    host.set_req(1'b1);
    k = 0;
    while (cfg_ok_n !== 1'b1) begin
      @(posedge core_clk);
      k++;
    end
    chk("ok_n hold", {31'h0, k >= cfg_loader_pkg::STATUS_MIN_CYC - 84 &&
      k <= cfg_loader_pkg::STATUS_MIN_CYC - 68}, 32'h1);
    if (hold) begin
      ahb(1'b0, cfg_loader_pkg::STATUS_ADDR, 32'h0);
      chk("held line", {28'h0, rd[cfg_loader_pkg::STAT_STATE_LSB +: 4]}, 32'h3);
      ok_hold_n <= 1'b1;
    end
    got.delete();
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hsize = 3'h0;
    clk_en = 1'b1;
    ok_hold_n = 1'b1;
    mode_select_pins = 3'h6;
    for (int w = 0; w < 3; w++) begin
      boot({1'b1, w[1:0]}, 3'h0, 32'h3);
      load(3, 1, 32'hc3a5_7e18, w == 0 ? 32'hff : w == 1 ? 32'hffff : 32'hffff_ffff, 1'b0);
      to_user(1'b0);
    end
    boot(3'h3, 3'h1, 32'h2);
    load(2, 8, 32'h2468_ace1, 32'hffff_ffff, 1'b0);
    to_user(1'b0);
    host.pulse();
    host.pulse();
    ahb(1'b0, cfg_loader_pkg::COUNT_ADDR, 32'h0);
    chk("clock ignored", rd, 32'h2);
    boot(3'h6, 3'h2, 32'h2);
    load(2, 4, 32'h1357_9bdf, 32'hffff_ffff, 1'b1);
    ahb(1'b0, cfg_loader_pkg::STATUS_ADDR, 32'h0);
    chk("status err", {29'h0, rd[2:0]}, 32'h4);
    request(1'b1);
    load(2, 4, 32'h1357_9bdf, 32'hffff_ffff, 1'b0);
    to_user(1'b0);
    boot(3'h6, 3'h7, 32'h1);
    load(1, 8, 32'h0f1e_2d3c, 32'hffff_ffff, 1'b0);
    to_user(1'b1);
    freeze();
    request(1'b0);
    stop_test();
  end
endmodule // parallel_config_loader_test
